/* ssr_defines.svh */
// Register offsets, field positions, reset values, counts and status match values of the sense status reporter
`ifndef SSR_DEFINES_SVH
`define SSR_DEFINES_SVH

// ****************************************************************
// Register byte offsets
// ****************************************************************
`define SSR_OFS_CTRL      12'h000
`define SSR_OFS_SCOUNT    12'h004
`define SSR_OFS_SEL0      12'h008
`define SSR_OFS_SEL1      12'h00C
`define SSR_OFS_SEL2      12'h010
`define SSR_OFS_SEL3      12'h014
`define SSR_OFS_STATUS    12'h018
`define SSR_OFS_INT_STAT  12'h01C
`define SSR_OFS_INT_EN    12'h020
`define SSR_OFS_INT_CLR   12'h024
`define SSR_OFS_TM_RESP   12'h028
`define SSR_OFS_SEL_INFO  12'h02C

// ****************************************************************
// Field positions
// ****************************************************************
`define SSR_CTRL_TGT_EN   0
`define SSR_CTRL_INIT_EN  1
`define SSR_CTRL_IRS      2
`define SSR_CTRL_EXT      3
`define SSR_INT_DONE      0
`define SSR_INT_SEL       1
`define SSR_INT_REJ       2
`define SSR_FLAG_CC       7
`define SSR_FLAG_ERR      6
`define SSR_FLAG_CONT     2

// ****************************************************************
// Reset values, counts, and the Check Condition status code and mask
// ****************************************************************
`define SSR_CTRL_RST      4'h2
`define SSR_SCOUNT_MAX    6'h20
`define SSR_SLOTS         8
`define SSR_CHK_COND      8'h02
`define SSR_STAT_MASK     8'h3E

`endif

/* ssr_pkg.sv */
// Types shared by the sense status reporter
package ssr_pkg;

  typedef enum logic [1:0] {SSR_M_DEFAULT, SSR_M_SEQ, SSR_M_SEL} ssr_mode_e;

  typedef struct packed {
    logic [31:0] id;
    logic [7:0]  scsi_status;
    logic [7:0]  error;
    logic [7:0]  flags;
  } ssr_cmd_s;

  typedef struct packed {
    logic        sel_rec;
    logic [1:0]  blk;
    logic [1:0]  word;
    logic [31:0] data;
  } ssr_word_s;

  typedef logic [7:0] ssr_byte_t;

endpackage

/* ssr_sense_mem.sv */
// Sense byte store filled by the Request Sense data phase
`timescale 1ns/1ps
module ssr_sense_mem
  import ssr_pkg::*;
(
  input  wire logic      pclk,
  input  wire logic      presetn,
  input  wire logic      clr,
  input  wire logic      wr_en,
  input  wire ssr_byte_t wr_byte,
  input  wire logic [7:0] rd_pos,
  output ssr_byte_t      rd_byte
);

  ssr_byte_t  mem [0:255];
  logic [8:0] len;

  // Positions the device never returned read as zero
  assign rd_byte = ({1'b0, rd_pos} < len) ? mem[rd_pos] : 8'h00;

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      len <= 9'h000;
    else if (clr)
      len <= 9'h000;
    else if (wr_en && len != 9'h100)
      len <= len + 9'h001;
  end

  always_ff @(posedge pclk)
  begin
    if (wr_en && !clr && len != 9'h100)
      mem[len[7:0]] <= wr_byte;
  end

endmodule

/* ssr_top.sv */
// Sense status reporter: builds status blocks with sense bytes and handles target selections
`timescale 1ns/1ps
`include "ssr_defines.svh"

// Behaviour
// R1: Zero count and zero selections report sense bytes 0..7 in natural order.
// R2: Default mode writes exactly one status block per command.
// R3: Nonzero count up to 32 reports that many leading bytes, ignoring selections.
// R4: More than eight sequential bytes spread over blocks, eight per block.
// R5: Selectable mode reports host-chosen byte positions in host order.
// R6: Basic unit options give eight selection fields.
// R7: Extended unit options give sixteen selections over multiple blocks.
// R8: Host selects by zero count and loading selection fields with byte numbers.
// R9: Sixteen-selection case: block one bytes 0..7, block two selected bytes.
// R10: Adapter may be target, initiator, or both at once.
// R11: Target enabled accepts selections; initiator work continues alongside.
// R12: Selection info goes to host memory; host supplies response by command.
// R13: Sense bytes sit in block words at offsets 08H and 0CH.
// R14: Check Condition triggers Request Sense unless inhibit_request_sense set.
// R15: Sense fields zero without Check Condition or with sense inhibited.
// R16: continued_status_flag set in series blocks, clear in first block.
// R17: Every continuation block repeats the command identifier.
// R18: Unused sense positions in last block are written as zero.
module ssr_top
  import ssr_pkg::*;
(
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        cmd_valid,
  input  wire ssr_cmd_s    cmd,
  output logic             cmd_ready,
  output logic             rs_req,
  input  wire logic        sense_valid,
  input  wire ssr_byte_t   sense_byte,
  input  wire logic        sense_last,
  input  wire logic        sel_valid,
  input  wire logic [31:0] sel_info,
  output logic             sel_disconnect,
  output logic             resp_valid,
  output logic      [31:0] resp_data,
  output logic             wr_valid,
  output ssr_word_s        wr,
  input  wire logic        wr_ready,
  output logic       [1:0] role,
  output logic             irq
);

  typedef enum logic [2:0] {ST_IDLE, ST_SENSE, ST_LOAD, ST_BUILD, ST_PUT} ssr_state_e;

  // ****************************************************************
  // Register bus
  // ****************************************************************
  logic [3:0]  ctrl;
  logic [5:0]  scount;
  logic [7:0]  sel_f [0:15];
  logic [2:0]  int_stat;
  logic [2:0]  int_en;
  logic [31:0] sel_last;
  logic [1:0]  last_nblk;

  wire setup_ph  = psel && penable && !pready;
  wire access_ph = psel && penable && pready;
  wire wr_acc    = access_ph && pwrite;

  wire hit_ctrl  = paddr == `SSR_OFS_CTRL;
  wire hit_scnt  = paddr == `SSR_OFS_SCOUNT;
  wire hit_sel   = paddr >= `SSR_OFS_SEL0 && paddr <= `SSR_OFS_SEL3 && paddr[1:0] == 2'h0;
  wire hit_stat  = paddr == `SSR_OFS_STATUS;
  wire hit_ist   = paddr == `SSR_OFS_INT_STAT;
  wire hit_ien   = paddr == `SSR_OFS_INT_EN;
  wire hit_iclr  = paddr == `SSR_OFS_INT_CLR;
  wire hit_resp  = paddr == `SSR_OFS_TM_RESP;
  wire hit_sinfo = paddr == `SSR_OFS_SEL_INFO;
  wire hit_any   = hit_ctrl | hit_scnt | hit_sel | hit_stat | hit_ist | hit_ien | hit_iclr | hit_resp | hit_sinfo;
  wire [1:0] sel_grp = 2'(paddr[4:2] - 3'h2);

  logic       busy;
  wire [31:0] sel_word = {sel_f[{sel_grp, 2'h3}], sel_f[{sel_grp, 2'h2}],
                          sel_f[{sel_grp, 2'h1}], sel_f[{sel_grp, 2'h0}]};
  wire [31:0] rd_mux =
    hit_ctrl  ? {28'h0000000, ctrl} :
    hit_scnt  ? {26'h0000000, scount} :
    hit_sel   ? sel_word :
    hit_stat  ? {27'h0000000, last_nblk, ctrl[`SSR_CTRL_INIT_EN], ctrl[`SSR_CTRL_TGT_EN], busy} :
    hit_ist   ? {29'h0000000, int_stat} :
    hit_ien   ? {29'h0000000, int_en} :
    hit_sinfo ? sel_last : 32'h00000000;

  // One wait state: pready rises in the second access cycle
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pready  <= 1'b0;
      prdata  <= 32'h00000000;
      pslverr    <= 1'b0;
      resp_valid <= 1'b0;
      resp_data  <= 32'h00000000;
    end
    else
    begin
      pready     <= setup_ph;
      prdata     <= (setup_ph && !pwrite) ? rd_mux : 32'h00000000;
      pslverr    <= setup_ph && !hit_any;
      // Host response command passes straight to the target side
      resp_valid <= wr_acc && hit_resp;                             // see R12
      resp_data  <= (wr_acc && hit_resp) ? pwdata : resp_data;
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      ctrl   <= `SSR_CTRL_RST;
      scount <= 6'h00;
      int_en <= 3'h0;
      for (int i = 0; i < 16; i++)
        sel_f[i] <= 8'h00;
    end
    else if (wr_acc)
    begin
      if (hit_ctrl)
        ctrl <= pwdata[3:0];                                        // see R10
      if (hit_scnt)
        scount <= (pwdata[5:0] > `SSR_SCOUNT_MAX) ? `SSR_SCOUNT_MAX : pwdata[5:0];  // see R3
      if (hit_ien)
        int_en <= pwdata[2:0];
      if (hit_sel)
        for (int b = 0; b < 4; b++)
          sel_f[{sel_grp, 2'(b)}] <= pwdata[8*b +: 8];              // see R8
    end
  end

  // ****************************************************************
  // Command capture and mode choice
  // ****************************************************************
  ssr_state_e state;
  ssr_cmd_s   cur;
  ssr_mode_e  mode;
  logic       ext;
  logic [5:0] cnt;
  logic       have_sense;
  logic [1:0] blk;
  logic [1:0] nblk;
  logic [1:0] word;
  logic [1:0] slot;
  logic [31:0] acc;
  logic        is_sel;

  wire any_sel = |{sel_f[0], sel_f[1], sel_f[2], sel_f[3], sel_f[4], sel_f[5], sel_f[6], sel_f[7],
                   sel_f[8], sel_f[9], sel_f[10], sel_f[11], sel_f[12], sel_f[13], sel_f[14], sel_f[15]};
  wire ssr_mode_e next_mode = (scount != 6'h00) ? SSR_M_SEQ : (any_sel ? SSR_M_SEL : SSR_M_DEFAULT);
  wire check_cond = (cmd.scsi_status & `SSR_STAT_MASK) == `SSR_CHK_COND;
  wire take_cmd   = cmd_valid && cmd_ready;
  wire take_sel   = sel_valid && cmd_ready && !cmd_valid;
  wire do_sense   = check_cond && !ctrl[`SSR_CTRL_IRS];

  // Index of the last block in the series for each mode (one less than the number of blocks)
  function automatic logic [1:0] blocks(input ssr_mode_e m, input logic e, input logic [5:0] c);
    logic [5:0] r;
    r = 6'((c + 6'h07) >> 3);
    case (m)
      SSR_M_SEQ: blocks = (r == 6'h04) ? 2'h3 : 2'(r - 6'h01);     // see R4
      SSR_M_SEL: blocks = e ? 2'h1 : 2'h0;                          // see R7
      default:   blocks = 2'h0;                                     // see R2
    endcase
  endfunction

  // Source position of one sense slot, bit 8 marks a used slot
  function automatic logic [8:0] src(input ssr_mode_e m, input logic e, input logic [5:0] c,
                                     input logic [1:0] b, input logic [2:0] s);
    logic [4:0] idx;
    idx = {b, s};
    case (m)
      SSR_M_SEQ: src = {({1'b0, idx} < c), 3'h0, idx};              // see R3 R18
      SSR_M_SEL:
        if (e && b == 2'h0)
          src = {1'b1, 5'h00, s};                                   // see R9
        else
          src = {1'b1, sel_f[{e, s}]};                              // see R5 R6 R9
      default:   src = {1'b1, 5'h00, s};                            // see R1
    endcase
  endfunction

  wire [8:0]  cur_src = src(mode, ext, cnt, blk, {word[0], slot});
  ssr_byte_t  mem_byte;
  wire        mem_clr = take_cmd;
  wire ssr_byte_t next_byte = (have_sense && cur_src[8]) ? mem_byte : 8'h00;  // see R15 R18

  ssr_sense_mem u_mem (
    .pclk    (pclk),
    .presetn (presetn),
    .clr     (mem_clr),
    .wr_en   (state == ST_SENSE && sense_valid),
    .wr_byte (sense_byte),
    .rd_pos  (cur_src[7:0]),
    .rd_byte (mem_byte)
  );

  wire [7:0] flag_byte = {1'b1, cur.error != 8'h00, cur.flags[5:3], blk != 2'h0, cur.flags[1:0]};  // see R16
  wire [31:0] next_hdr = (word == 2'h0) ? cur.id :                 // see R17
                         {flag_byte, cur.error, cur.scsi_status, 8'h00};

  // ****************************************************************
  // Status block sequencer
  // ****************************************************************
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      state      <= ST_IDLE;
      cur        <= '0;
      mode       <= SSR_M_DEFAULT;
      ext        <= 1'b0;
      cnt        <= 6'h00;
      have_sense <= 1'b0;
      blk        <= 2'h0;
      nblk       <= 2'h0;
      word       <= 2'h0;
      slot       <= 2'h0;
      acc        <= 32'h00000000;
      is_sel     <= 1'b0;
      rs_req     <= 1'b0;
      wr_valid   <= 1'b0;
      wr         <= '0;
      sel_last   <= 32'h00000000;
      last_nblk  <= 2'h0;
    end
    else
    begin
      rs_req <= 1'b0;
      unique case (state)
        ST_IDLE:
          if (take_cmd)
          begin
            cur        <= cmd;
            mode       <= next_mode;
            ext        <= ctrl[`SSR_CTRL_EXT];
            cnt        <= scount;
            nblk       <= blocks(next_mode, ctrl[`SSR_CTRL_EXT], scount);
            blk        <= 2'h0;
            word       <= 2'h0;
            is_sel     <= 1'b0;
            have_sense <= do_sense;
            rs_req     <= do_sense;                                 // see R14
            state      <= do_sense ? ST_SENSE : ST_LOAD;
          end
          else if (take_sel && ctrl[`SSR_CTRL_TGT_EN])
          begin
            sel_last <= sel_info;
            is_sel   <= 1'b1;
            wr_valid <= 1'b1;                                       // see R11 R12
            wr       <= '{sel_rec: 1'b1, blk: 2'h0, word: 2'h0, data: sel_info};
            state    <= ST_PUT;
          end
        ST_SENSE:
          if (sense_valid && sense_last)
            state <= ST_LOAD;
        ST_LOAD:
        begin
          // Header words go out at once, sense words are built first
          slot     <= 2'h0;
          wr_valid <= !word[1];
          wr       <= '{sel_rec: 1'b0, blk: blk, word: word, data: next_hdr};
          state    <= word[1] ? ST_BUILD : ST_PUT;
        end
        ST_BUILD:
        begin
          acc  <= {next_byte, acc[31:8]};                           // see R13
          slot <= 2'(slot + 2'h1);
          if (slot == 2'h3)
          begin
            wr_valid <= 1'b1;
            wr       <= '{sel_rec: 1'b0, blk: blk, word: word, data: {next_byte, acc[31:8]}};
            state    <= ST_PUT;
          end
        end
        ST_PUT:
          if (wr_ready)
          begin
            wr_valid <= 1'b0;
            word     <= 2'(word + 2'h1);
            state    <= (is_sel || (word == 2'h3 && blk == nblk)) ? ST_IDLE : ST_LOAD;
            if (!is_sel && word == 2'h3 && blk != nblk)
              blk <= 2'(blk + 2'h1);                                // see R4 R7
            if (!is_sel && word == 2'h3 && blk == nblk)
              last_nblk <= nblk;
          end
        default:
          state <= ST_IDLE;
      endcase
    end
  end

  wire series_done = state == ST_PUT && wr_ready && !is_sel && word == 2'h3 && blk == nblk;
  wire sel_taken   = state == ST_IDLE && take_sel && ctrl[`SSR_CTRL_TGT_EN];
  wire sel_refused = state == ST_IDLE && take_sel && !ctrl[`SSR_CTRL_TGT_EN];

  // ****************************************************************
  // Handshake, role and interrupt outputs
  // ****************************************************************
  wire [2:0] events = {sel_refused, sel_taken, series_done};
  wire [2:0] clr_m  = (wr_acc && hit_iclr) ? pwdata[2:0] : 3'h0;

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      cmd_ready      <= 1'b0;
      busy           <= 1'b0;
      sel_disconnect <= 1'b0;
      role           <= 2'h0;
      int_stat       <= 3'h0;
      irq            <= 1'b0;
    end
    else
    begin
      // Ready drops in the cycle after a request is taken, so none is taken twice
      cmd_ready      <= (state == ST_IDLE && !take_cmd && !take_sel) || series_done ||
                        (state == ST_PUT && is_sel && wr_ready);
      busy           <= state != ST_IDLE;
      sel_disconnect <= sel_refused;
      role           <= {ctrl[`SSR_CTRL_TGT_EN], ctrl[`SSR_CTRL_INIT_EN]};  // see R10
      int_stat       <= (int_stat & ~clr_m) | events;
      irq            <= |(((int_stat & ~clr_m) | events) & int_en);
    end
  end

endmodule

/* ssr_assertions.sv */
// Port-level checker of the sense status reporter, bound into its top module
`timescale 1ns/1ps
`include "ssr_defines.svh"
module ssr_assertions
  import ssr_pkg::*;
(
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic [31:0] prdata,
  input  wire logic        pready,
  input  wire logic        pslverr,
  input  wire logic        cmd_valid,
  input  wire ssr_cmd_s    cmd,
  input  wire logic        cmd_ready,
  input  wire logic        rs_req,
  input  wire logic        wr_valid,
  input  wire ssr_word_s   wr,
  input  wire logic        wr_ready
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  // ****************************************************************
  // Register bus
  // ****************************************************************
  a_bus_wait: assert property (psel && penable && !$past(penable) |=> pready) else $error("pready not in 2nd access");
  a_ready_pulse: assert property (pready |=> !pready) else $error("pready held");
  a_err_ready: assert property (pslverr |-> pready && psel && penable) else $error("pslverr outside answer");
  a_rdata_idle: assert property (!pready |-> prdata == 32'h0) else $error("prdata not zero");

  // ****************************************************************
  // Status blocks
  // ****************************************************************
  a_sense_cause: assert property (rs_req |-> $past(cmd_valid && cmd_ready &&
    (cmd.scsi_status & `SSR_STAT_MASK) == `SSR_CHK_COND)) else $error("sense request without cause");
  a_req_pulse: assert property (rs_req |=> !rs_req) else $error("rs_req held");
  a_no_queue: assert property (cmd_valid && cmd_ready |=> !cmd_ready) else $error("cmd_ready while busy");
  a_first_word: assert property (cmd_valid && cmd_ready && (cmd.scsi_status & `SSR_STAT_MASK) != `SSR_CHK_COND
    |-> ##2 wr_valid && !wr.sel_rec && wr.blk == 2'h0 && wr.word == 2'h0 && wr.data == $past(cmd.id, 2))
    else $error("first word wrong");
  a_word_hold: assert property (wr_valid && !wr_ready |=> wr_valid && $stable(wr)) else $error("word dropped");
  a_cont_flag: assert property (wr_valid && !wr.sel_rec && wr.word == 2'h1
    |-> wr.data[24 + `SSR_FLAG_CONT] == (wr.blk != 2'h0)) else $error("continued flag wrong");
  a_sel_word: assert property (wr_valid && wr.sel_rec |-> wr.blk == 2'h0 && wr.word == 2'h0)
    else $error("selection record misplaced");
endmodule

bind ssr_top ssr_assertions i_chk (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
  .prdata(prdata), .pready(pready), .pslverr(pslverr), .cmd_valid(cmd_valid), .cmd(cmd),
  .cmd_ready(cmd_ready), .rs_req(rs_req), .wr_valid(wr_valid), .wr(wr), .wr_ready(wr_ready));

/* ssr_host_model.sv */
// Behavioural host memory and sense-returning device on the far side of the reporter
`timescale 1ns/1ps
module ssr_host_model
  import ssr_pkg::*;
(
  input  wire logic       pclk,
  input  wire logic       rs_req,
  input  wire logic [8:0] sense_len,
  input  wire logic       slow,
  input  wire logic       wr_valid,
  input  wire ssr_word_s  wr,
  output logic            sense_valid,
  output ssr_byte_t       sense_byte,
  output logic            sense_last,
  output logic            wr_ready
);
  logic [31:0] mem [4][4];
  logic [31:0] selw;
  logic        act = 1'b0;
  logic        tick = 1'b0;
  int          nwords = 0, nrs = 0, nsel = 0, pos = 0;

  // Idle data toggles every cycle so a stale byte is never mistaken for sense data
  assign sense_valid = act;
  assign sense_byte  = act ? (pos[7:0] ^ 8'h5A) : {4{tick, !tick}};
  assign sense_last  = act && (pos == int'(sense_len) - 1);
  // Slow memory accepts only every other cycle
  assign wr_ready    = !slow || tick;

  always @(posedge pclk)
  begin
    tick <= !tick;
    nrs <= nrs + int'(rs_req);
    if (rs_req)
    begin
      act <= 1'b1;
      pos <= 0;
    end
    else if (act)
    begin
      act <= !sense_last;
      pos <= pos + 1;
    end
    if (wr_valid && wr_ready)
    begin
      nwords <= nwords + int'(!wr.sel_rec);
      nsel <= nsel + int'(wr.sel_rec);
      if (wr.sel_rec)
        selw <= wr.data;
      else
        mem[wr.blk][wr.word] <= wr.data;
    end
  end
endmodule

/* ssr_tb.sv */
// Self-checking testbench of the sense status reporter
`timescale 1ns/1ps
`include "ssr_defines.svh"
`define CHK(g, x) begin cmp_count++; if ((g) !== (x)) begin failures++; \
  $display("[FAIL] %0t got %0h exp %0h", $time, (g), (x)); end end
`define WAITN(c) begin n = 0; do begin @(negedge pclk); n++; end while (!(c) && n < 3000); \
  if (n >= 3000) begin failures++; $display("[FAIL] %0t timeout", $time); summarize(); end end
module testbench
  import ssr_pkg::*;
;
  logic        pclk, presetn, psel, penable, pwrite, cmd_valid, sel_valid, slow, e;
  logic [11:0] paddr;
  logic [31:0] pwdata, sel_info, prdata, resp_data, q, resp_last;
  logic        pready, pslverr, cmd_ready, rs_req, sense_valid, sense_last, sel_disconnect;
  logic        resp_valid, wr_valid, wr_ready, irq;
  logic [1:0]  role;
  logic [8:0]  sense_len;
  ssr_cmd_s    cmd;
  ssr_word_s   wr;
  ssr_byte_t   sense_byte;
  ssr_byte_t   exp_b [4][8];
  int          failures = 0, cmp_count = 0, n_disc = 0, n_resp = 0;

  ssr_top i_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .cmd_valid(cmd_valid), .cmd(cmd), .cmd_ready(cmd_ready), .rs_req(rs_req), .sense_valid(sense_valid),
    .sense_byte(sense_byte), .sense_last(sense_last), .sel_valid(sel_valid), .sel_info(sel_info),
    .sel_disconnect(sel_disconnect), .resp_valid(resp_valid), .resp_data(resp_data),
    .wr_valid(wr_valid), .wr(wr), .wr_ready(wr_ready), .role(role), .irq(irq));
  ssr_host_model i_host (.pclk(pclk), .rs_req(rs_req), .sense_len(sense_len), .slow(slow),
    .wr_valid(wr_valid), .wr(wr), .sense_valid(sense_valid), .sense_byte(sense_byte),
    .sense_last(sense_last), .wr_ready(wr_ready));

  initial
  begin
    pclk = 1'b0;
    forever #5 pclk = ~pclk;
  end

  always @(posedge pclk)
  begin
    n_disc <= n_disc + int'(sel_disconnect === 1'b1);
    n_resp <= n_resp + int'(resp_valid === 1'b1);
    if (resp_valid === 1'b1)
      resp_last <= resp_data;
  end

  function automatic ssr_byte_t sb(input int p);
    return p[7:0] ^ 8'h5A;
  endfunction

  task automatic summarize();
    $display("failures=%0d comparisons=%0d", failures, cmp_count);
    if (failures == 0 && cmp_count > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask

  // ****************************************************************
  // Bus and command drivers
  // ****************************************************************
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int n;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    `WAITN(pready === 1'b1)
    @(posedge pclk);
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(negedge pclk);
  endtask

  task automatic sel_ev(input logic [31:0] info);
    int n;
    @(posedge pclk);
    sel_valid <= 1'b1;
    sel_info <= info;
    `WAITN(cmd_ready === 1'b1)
    @(posedge pclk);
    sel_valid <= 1'b0;
  endtask

  task automatic run_cmd(input logic [31:0] id, input logic [7:0] st, input int nblk, input int nrs);
    int n, w0, r0, b;
    w0 = i_host.nwords;
    r0 = i_host.nrs;
    @(posedge pclk);
    cmd_valid <= 1'b1;
    cmd <= '{id: id, scsi_status: st, error: 8'h00, flags: 8'h21};
    `WAITN(cmd_ready === 1'b1)
    @(posedge pclk);
    cmd_valid <= 1'b0;
    `WAITN(cmd_ready === 1'b1)
    `CHK(i_host.nwords - w0, 4 * nblk)
    `CHK(i_host.nrs - r0, nrs)
    for (b = 0; b < nblk; b++)
    begin
      `CHK(i_host.mem[b][0], id)
      `CHK(i_host.mem[b][1], {5'h14, b != 0, 2'h1, 8'h00, st, 8'h00})
      `CHK(i_host.mem[b][2], {exp_b[b][3], exp_b[b][2], exp_b[b][1], exp_b[b][0]})
      `CHK(i_host.mem[b][3], {exp_b[b][7], exp_b[b][6], exp_b[b][5], exp_b[b][4]})
    end
  endtask

  // ****************************************************************
  // Scenarios
  // ****************************************************************
  task automatic t_default();
    int s;
    apb(1'b0, `SSR_OFS_CTRL, 32'h0);
    `CHK(q, 32'h2)
    `CHK(role, 2'h1)
    apb(1'b0, 12'h030, 32'h0);
    `CHK(e, 1'h1)
    `CHK(q, 32'h0)
    exp_b = '{default: 8'h00};
    for (s = 0; s < 8; s++)
      exp_b[0][s] = sb(s);
    sense_len <= 9'h014;
    // Reserved status bit set still reads as Check Condition
    run_cmd(32'h1000_0001, 8'h03, 1, 1);
    exp_b = '{default: 8'h00};
    run_cmd(32'h1000_0002, 8'h08, 1, 0);
    apb(1'b1, `SSR_OFS_CTRL, 32'h6);
    run_cmd(32'h1000_0003, 8'h02, 1, 0);
    apb(1'b1, `SSR_OFS_CTRL, 32'h2);
  endtask

  task automatic t_seq();
    int s;
    apb(1'b1, `SSR_OFS_SEL0, 32'h0403_0201);
    apb(1'b1, `SSR_OFS_SCOUNT, 32'hC);
    slow <= 1'b1;
    for (s = 0; s < 12; s++)
      exp_b[s / 8][s % 8] = sb(s);
    run_cmd(32'h2000_0004, 8'h02, 2, 1);
    apb(1'b1, `SSR_OFS_SCOUNT, 32'h3F);
    apb(1'b0, `SSR_OFS_SCOUNT, 32'h0);
    `CHK(q, 32'h20)
    for (s = 0; s < 32; s++)
      exp_b[s / 8][s % 8] = sb(s);
    sense_len <= 9'h028;
    run_cmd(32'h2000_0005, 8'h02, 4, 1);
    apb(1'b0, `SSR_OFS_STATUS, 32'h0);
    `CHK(q, 32'h1C)
    slow <= 1'b0;
    apb(1'b1, `SSR_OFS_SCOUNT, 32'h0);
    apb(1'b1, `SSR_OFS_SEL0, 32'h0);
  endtask

  task automatic t_sel();
    int s;
    int pick [8] = '{200, 3, 7, 255, 2, 16, 128, 1};
    int ext [8] = '{56, 57, 12, 19, 122, 33, 12, 23};
    apb(1'b1, `SSR_OFS_SEL0, 32'hFF07_03C8);
    apb(1'b1, `SSR_OFS_SEL1, 32'h0180_1002);
    sense_len <= 9'h100;
    exp_b = '{default: 8'h00};
    for (s = 0; s < 8; s++)
      exp_b[0][s] = sb(pick[s]);
    run_cmd(32'h3000_0006, 8'h02, 1, 1);
    apb(1'b1, `SSR_OFS_SEL0, 32'h0);
    apb(1'b1, `SSR_OFS_SEL1, 32'h0);
    apb(1'b1, `SSR_OFS_CTRL, 32'hA);
    apb(1'b1, `SSR_OFS_SEL2, 32'h130C_3938);
    apb(1'b1, `SSR_OFS_SEL3, 32'h170C_217A);
    for (s = 0; s < 8; s++)
    begin
      exp_b[0][s] = sb(s);
      exp_b[1][s] = sb(ext[s]);
    end
    run_cmd(32'h3000_0007, 8'h02, 2, 1);
    apb(1'b1, `SSR_OFS_CTRL, 32'h2);
  endtask

  task automatic t_target();
    int n, k;
    apb(1'b1, `SSR_OFS_INT_CLR, 32'h7);
    apb(1'b1, `SSR_OFS_INT_EN, 32'h7);
    `CHK(irq, 1'h0)
    sel_ev(32'h0000_00A1);
    `WAITN(n_disc == 1)
    apb(1'b0, `SSR_OFS_INT_STAT, 32'h0);
    `CHK(q, 32'h4)
    `CHK(irq, 1'h1)
    apb(1'b1, `SSR_OFS_INT_EN, 32'h0);
    @(negedge pclk);
    `CHK(irq, 1'h0)
    apb(1'b1, `SSR_OFS_INT_CLR, 32'h4);
    apb(1'b1, `SSR_OFS_INT_EN, 32'h7);
    apb(1'b1, `SSR_OFS_CTRL, 32'h3);
    @(negedge pclk);
    `CHK(role, 2'h3)
    k = i_host.nsel;
    sel_ev(32'h5E1E_C7ED);
    `WAITN(i_host.nsel == k + 1)
    `CHK(i_host.selw, 32'h5E1E_C7ED)
    apb(1'b0, `SSR_OFS_SEL_INFO, 32'h0);
    `CHK(q, 32'h5E1E_C7ED)
    apb(1'b0, `SSR_OFS_INT_STAT, 32'h0);
    `CHK(q, 32'h2)
    exp_b = '{default: 8'h00};
    run_cmd(32'h4000_0008, 8'h00, 1, 0);
    apb(1'b1, `SSR_OFS_TM_RESP, 32'h0BAD_F00D);
    `WAITN(n_resp == 1)
    `CHK(resp_last, 32'h0BAD_F00D)
    apb(1'b1, `SSR_OFS_INT_CLR, 32'h7);
    apb(1'b0, `SSR_OFS_INT_STAT, 32'h0);
    `CHK(q, 32'h0)
    `CHK(irq, 1'h0)
  endtask

  initial
  begin
    {presetn, psel, penable, pwrite, cmd_valid, sel_valid, slow} = 7'h00;
    paddr = 12'h000;
    pwdata = 32'h0;
    sel_info = 32'h0;
    cmd = '0;
    sense_len = 9'h008;
    repeat (16) @(posedge pclk);
    presetn <= 1'b1;
    t_default();
    t_seq();
    t_sel();
    t_target();
    summarize();
  end
endmodule
